// ### hdl/pior_bank.sv
// How it works
// - four read-only analog input registers, 0.1 percent units
// - terminals exchange data only on the end-of-scan strobe
// - inputs are raw instantaneous samples, no filtering applied
// - analog output follows its register only when its source select is 70
// - run register 1 counts pulses, 0 stops counting
// - sample register holds last cycle's scaled count, 0 to 32767
// - sample equals raw pulses times prescale times increment factor
// - increment select 0 none, 1..5 x1 down to x0.0001, reset 0
// - prescale accepts 0 to 32767, resets to 1
// - cumulative count spans low and high words, 0 to 99999999
// - clear request 1 clears the counts, 0 leaves them
// - pid reads set point and measured value, writes manipulated amount
// - modes 70,71,80,81 compute only after drive start, else 0
// - modes 90..101 compute on control 1, no effect on frequency
// - action select decodes disabled, deviation and measured modes
// - second independent pid instance with its own registers
// - set point 0..100 percent, deviation -100..100, 0.01 percent
// - out-of-range pid inputs operate at the nearest limit
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pior_bank
    import pior_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        end_of_scan,
    input  wire logic [63:0] analog_in_raw,
    output logic      [79:0] analog_out,
    input  wire logic [15:0] pulse_in_count,
    input  wire logic        drive_running,
    input  wire logic        pid_enable_input,
    input  wire logic        second_pid_enable_input,
    input  wire logic        pid_enable_assigned,
    input  wire logic        second_pid_enable_assigned,
    output logic             pid_freq_apply
);

    function automatic logic signed [15:0] clamp_pct(
        input logic signed [15:0] v, input logic signed [15:0] lo);
        if (v > PCT_MAX) clamp_pct = PCT_MAX;
        else if (v < lo) clamp_pct = lo;
        else clamp_pct = v;
    endfunction

    function automatic pior_pid_mode_type decode_act(
        input logic [15:0] a, input logic run, input logic ctl);
        pior_pid_mode_type m;
        m = '0;
        case (a)
            ACT_DEV_REV_RUN, ACT_DEV_FWD_RUN,
            ACT_MS_REV_RUN, ACT_MS_FWD_RUN: begin
                m.enabled = 1'b1;
                m.active  = ctl && run;
            end
            ACT_DEV_REV_FREE, ACT_DEV_FWD_FREE,
            ACT_MS_REV_FREE, ACT_MS_FWD_FREE: begin
                m.enabled = 1'b1;
                m.active  = ctl;
            end
            default: m = '0;
        endcase
        m.forward   = a[0];
        m.deviation = (a == ACT_DEV_REV_RUN) || (a == ACT_DEV_FWD_RUN) ||
                      (a == ACT_DEV_REV_FREE) || (a == ACT_DEV_FWD_FREE);
        decode_act = m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] ain_reg [NUM_AIN];
    logic [15:0] aout_reg [NUM_AOUT];
    logic [15:0] aout_sel_reg [NUM_AOUT];
    logic [79:0] analog_out_reg;
    logic [15:0] sample_reg;
    logic [31:0] cum_reg;
    logic        clear_reg;
    logic        run_reg;
    logic [2:0]  inc_scale_reg;
    logic [15:0] prescale_reg;
    logic [15:0] pulse_io_sel_reg;
    logic [15:0] pulse_div_reg;
    logic [15:0] sp_reg [2];
    logic [15:0] pv_reg [2];
    logic [15:0] mv_reg [2];
    logic        ctl_reg [2];
    logic [15:0] act_reg [2];
    logic        freq_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    logic        pready_reg;
    pior_cnt_state_type st_reg;
    logic [31:0] prod_reg;

    logic wr_en;
    logic rd_en;
    logic hit;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    ////////////////////////////////////////////////////////////////////////
    // analog input and output exchange, only at end of scan
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_AIN; i++) ain_reg[i] <= 16'h0000;
            analog_out_reg <= 80'h0;
        end else if (end_of_scan) begin
            for (int i = 0; i < NUM_AIN; i++)
                ain_reg[i] <= analog_in_raw[16*i +: 16];
            for (int i = 0; i < NUM_AOUT; i++)
                if (aout_sel_reg[i] == AOUT_SRC_PROGRAM)
                    analog_out_reg[16*i +: 16] <= aout_reg[i];
        end
    end
    assign analog_out = analog_out_reg;

    ////////////////////////////////////////////////////////////////////////
    // software-written registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_AOUT; i++) begin
                aout_reg[i]     <= 16'h0000;
                aout_sel_reg[i] <= 16'h0000;
            end
            run_reg          <= 1'b0;
            inc_scale_reg    <= INC_SCALE_RESET;
            prescale_reg     <= PRESCALE_RESET;
            pulse_io_sel_reg <= 16'h0000;
            pulse_div_reg    <= 16'h0000;
            for (int k = 0; k < 2; k++) begin
                sp_reg[k]  <= 16'h0000;
                pv_reg[k]  <= 16'h0000;
                ctl_reg[k] <= 1'b0;
                act_reg[k] <= 16'h0000;
            end
        end else if (wr_en) begin
            case (paddr)
                OFS_AOUT_METER:   aout_reg[0] <= pwdata[15:0];
                OFS_AOUT_PRIMARY: aout_reg[1] <= pwdata[15:0];
                OFS_AOUT_OPT0:    aout_reg[2] <= pwdata[15:0];
                OFS_AOUT_OPT1:    aout_reg[3] <= pwdata[15:0];
                OFS_AOUT_DAC:     aout_reg[4] <= pwdata[15:0];
                OFS_AOUT_SEL:     aout_sel_reg[pwdata[18:16] < 3'h5 ?
                                  pwdata[18:16] : 3'h0] <= pwdata[15:0];
                OFS_PULSE_RUN:    run_reg <= pwdata[0];
                OFS_INC_SCALE:
                    if (pwdata[2:0] <= INC_SCALE_MAX)
                        inc_scale_reg <= pwdata[2:0];
                OFS_PRESCALE:
                    if (pwdata[15:0] <= PRESCALE_MAX)
                        prescale_reg <= pwdata[15:0];
                OFS_PULSE_IO_SEL: pulse_io_sel_reg <= pwdata[15:0];
                OFS_PULSE_DIV:    pulse_div_reg <= pwdata[15:0];
                OFS_PID_SP:       sp_reg[0] <= pwdata[15:0];
                OFS_PID_PV:       pv_reg[0] <= pwdata[15:0];
                OFS_PID_CTRL:     ctl_reg[0] <= pwdata[0];
                OFS_PID_ACTION:   act_reg[0] <= pwdata[15:0];
                OFS_PID2_SP:      sp_reg[1] <= pwdata[15:0];
                OFS_PID2_PV:      pv_reg[1] <= pwdata[15:0];
                OFS_PID2_CTRL:    ctl_reg[1] <= pwdata[0];
                OFS_PID2_ACTION:  act_reg[1] <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // clear request is a pulse: it self-clears after acting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) clear_reg <= 1'b0;
        else if (wr_en && paddr == OFS_PULSE_CLEAR)
            clear_reg <= pwdata[0];
        else if (end_of_scan) clear_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse counter: scaled on each end of scan while run is 1, from the raw cycle count
    logic [31:0] scaled;
    always_comb begin
        case (inc_scale_reg)
            3'h1: scaled = prod_reg;
            3'h2: scaled = prod_reg / 32'd10;
            3'h3: scaled = prod_reg / 32'd100;
            3'h4: scaled = prod_reg / 32'd1000;
            3'h5: scaled = prod_reg / 32'd10000;
            default: scaled = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg     <= ST_IDLE;
            prod_reg   <= 32'h0000_0000;
            sample_reg <= 16'h0000;
            cum_reg    <= 32'h0000_0000;
        end else if (clear_reg && end_of_scan) begin
            st_reg     <= ST_IDLE;
            sample_reg <= 16'h0000;
            cum_reg    <= 32'h0000_0000;
        end else begin
            case (st_reg)
                ST_IDLE:
                    if (end_of_scan && run_reg) begin
                        prod_reg <= {16'h0000, pulse_in_count} *
                                    {16'h0000, prescale_reg};
                        st_reg <= ST_MUL;
                    end
                ST_MUL: begin
                    sample_reg <= (scaled > {16'h0000, SAMPLE_MAX}) ?
                                  SAMPLE_MAX : scaled[15:0];
                    st_reg <= ST_ACC;
                end
                ST_ACC: begin
                    cum_reg <= (cum_reg + {16'h0000, sample_reg} > CUM_MAX)
                               ? CUM_MAX
                               : cum_reg + {16'h0000, sample_reg};
                    st_reg <= ST_IDLE;
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pid interface; the algorithm proper lives elsewhere, here a
    // proportional stand-in so the register path is exercised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mv_reg[0] <= 16'h0000;
            mv_reg[1] <= 16'h0000;
            freq_reg  <= 1'b0;
        end else if (end_of_scan) begin
            freq_reg <= 1'b0;
            for (int k = 0; k < 2; k++) begin
                pior_pid_mode_type m;
                logic signed [15:0] sp;
                logic signed [15:0] pv;
                logic signed [16:0] e;
                logic               en_ok;
                m  = decode_act(act_reg[k], drive_running, ctl_reg[k]);
                sp = clamp_pct(sp_reg[k], m.deviation ? PCT_MIN :
                               16'sh0000);
                pv = clamp_pct(pv_reg[k], 16'sh0000);
                e  = m.deviation ? 17'(sp) : 17'(sp) - 17'(pv);
                if (!m.forward) e = -e;
                en_ok = (k == 0) ? (!pid_enable_assigned || pid_enable_input)
                        : (!second_pid_enable_assigned ||
                           second_pid_enable_input);
                if (m.active && en_ok) begin
                    mv_reg[k] <= (e > 17'(PCT_MAX)) ? PCT_MAX :
                                 (e < 17'(PCT_MIN)) ? PCT_MIN : e[15:0];
                    if (act_reg[k] < ACT_DEV_REV_FREE)
                        freq_reg <= 1'b1;
                end else if (!m.active) begin
                    mv_reg[k] <= 16'h0000;
                end
            end
        end
    end
    assign pid_freq_apply = freq_reg;

    ////////////////////////////////////////////////////////////////////////
    // apb read side, zero wait states
    always_comb begin
        hit = 1'b1;
        case (paddr)
            OFS_AIN_ONE, OFS_AIN_TWO, OFS_AIN_FOUR, OFS_AIN_SIX,
            OFS_AOUT_METER, OFS_AOUT_PRIMARY, OFS_AOUT_OPT0, OFS_AOUT_OPT1,
            OFS_AOUT_DAC, OFS_PULSE_SAMPLE, OFS_PULSE_CUM_LO,
            OFS_PULSE_CUM_HI, OFS_PULSE_CLEAR, OFS_PULSE_RUN, OFS_PID_SP,
            OFS_PID_PV, OFS_PID_MV, OFS_PID_CTRL, OFS_PID2_SP, OFS_PID2_PV,
            OFS_PID2_MV, OFS_PID2_CTRL, OFS_PID_ACTION, OFS_PID2_ACTION,
            OFS_INC_SCALE, OFS_PRESCALE, OFS_AOUT_SEL, OFS_PULSE_IO_SEL,
            OFS_PULSE_DIV: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata_reg <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) begin
            case (paddr)
                OFS_AIN_ONE:      prdata_reg <= {16'h0, ain_reg[0]};
                OFS_AIN_TWO:      prdata_reg <= {16'h0, ain_reg[1]};
                OFS_AIN_FOUR:     prdata_reg <= {16'h0, ain_reg[2]};
                OFS_AIN_SIX:      prdata_reg <= {16'h0, ain_reg[3]};
                OFS_AOUT_METER:   prdata_reg <= {16'h0, aout_reg[0]};
                OFS_AOUT_PRIMARY: prdata_reg <= {16'h0, aout_reg[1]};
                OFS_AOUT_OPT0:    prdata_reg <= {16'h0, aout_reg[2]};
                OFS_AOUT_OPT1:    prdata_reg <= {16'h0, aout_reg[3]};
                OFS_AOUT_DAC:     prdata_reg <= {16'h0, aout_reg[4]};
                OFS_PULSE_SAMPLE: prdata_reg <= {16'h0, sample_reg};
                OFS_PULSE_CUM_LO: prdata_reg <= {16'h0, cum_reg[15:0]};
                OFS_PULSE_CUM_HI: prdata_reg <= {16'h0, cum_reg[31:16]};
                OFS_PULSE_CLEAR:  prdata_reg <= {31'h0, clear_reg};
                OFS_PULSE_RUN:    prdata_reg <= {31'h0, run_reg};
                OFS_PID_SP:       prdata_reg <= {16'h0, sp_reg[0]};
                OFS_PID_PV:       prdata_reg <= {16'h0, pv_reg[0]};
                OFS_PID_MV:       prdata_reg <= {16'h0, mv_reg[0]};
                OFS_PID_CTRL:     prdata_reg <= {31'h0, ctl_reg[0]};
                OFS_PID2_SP:      prdata_reg <= {16'h0, sp_reg[1]};
                OFS_PID2_PV:      prdata_reg <= {16'h0, pv_reg[1]};
                OFS_PID2_MV:      prdata_reg <= {16'h0, mv_reg[1]};
                OFS_PID2_CTRL:    prdata_reg <= {31'h0, ctl_reg[1]};
                OFS_PID_ACTION:   prdata_reg <= {16'h0, act_reg[0]};
                OFS_PID2_ACTION:  prdata_reg <= {16'h0, act_reg[1]};
                OFS_INC_SCALE:    prdata_reg <= {29'h0, inc_scale_reg};
                OFS_PRESCALE:     prdata_reg <= {16'h0, prescale_reg};
                OFS_PULSE_IO_SEL: prdata_reg <= {16'h0, pulse_io_sel_reg};
                OFS_PULSE_DIV:    prdata_reg <= {16'h0, pulse_div_reg};
                default:          prdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    // error flag loaded at setup so it stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pslverr_reg <= 1'b0;
        else if (psel && !penable) pslverr_reg <= !hit;
    end

    // zero wait states, but kept in a flop so every output is registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pready_reg <= 1'b1;
        else pready_reg <= 1'b1;
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////
    a_sample_range: assert property (@(posedge pclk) disable iff (!presetn)
        sample_reg <= SAMPLE_MAX)
        else $error("sample count above limit");
    a_cum_range: assert property (@(posedge pclk) disable iff (!presetn)
        cum_reg <= CUM_MAX)
        else $error("cumulative count above limit");
    a_ain_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(end_of_scan) |-> $stable(ain_reg[0]))
        else $error("analog input changed outside end of scan");
    a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg == ST_IDLE && !end_of_scan) |=> $stable(cum_reg))
        else $error("cumulative count moved while idle");
    a_mv_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (end_of_scan && act_reg[0] == ACT_DEV_REV_RUN && !drive_running)
        |=> mv_reg[0] == 16'h0000)
        else $error("manipulated amount not zero before start");
    a_clear_cnt: assert property (@(posedge pclk) disable iff (!presetn)
        (clear_reg && end_of_scan) |=> cum_reg == 32'h0)
        else $error("count not cleared on request");
    a_prescale_rng: assert property (@(posedge pclk) disable iff (!presetn)
        prescale_reg <= PRESCALE_MAX)
        else $error("prescale out of range");
    a_mv_range: assert property (@(posedge pclk) disable iff (!presetn)
        $signed(mv_reg[1]) <= PCT_MAX && $signed(mv_reg[1]) >= PCT_MIN)
        else $error("second manipulated amount out of range");

endmodule
`default_nettype wire

// ### hdl/pior_pkg.sv
package pior_pkg;

    // register byte offsets (no offsets are printed for this bank)
    localparam logic [7:0] OFS_AIN_ONE      = 8'h00;
    localparam logic [7:0] OFS_AIN_TWO      = 8'h04;
    localparam logic [7:0] OFS_AIN_FOUR     = 8'h08;
    localparam logic [7:0] OFS_AIN_SIX      = 8'h0C;
    localparam logic [7:0] OFS_AOUT_METER   = 8'h10;
    localparam logic [7:0] OFS_AOUT_PRIMARY = 8'h14;
    localparam logic [7:0] OFS_AOUT_OPT0    = 8'h18;
    localparam logic [7:0] OFS_AOUT_OPT1    = 8'h1C;
    localparam logic [7:0] OFS_AOUT_DAC     = 8'h20;
    localparam logic [7:0] OFS_PULSE_SAMPLE = 8'h24;
    localparam logic [7:0] OFS_PULSE_CUM_LO = 8'h28;
    localparam logic [7:0] OFS_PULSE_CUM_HI = 8'h2C;
    localparam logic [7:0] OFS_PULSE_CLEAR  = 8'h30;
    localparam logic [7:0] OFS_PULSE_RUN    = 8'h34;
    localparam logic [7:0] OFS_PID_SP       = 8'h38;
    localparam logic [7:0] OFS_PID_PV       = 8'h3C;
    localparam logic [7:0] OFS_PID_MV       = 8'h40;
    localparam logic [7:0] OFS_PID_CTRL     = 8'h44;
    localparam logic [7:0] OFS_PID2_SP      = 8'h48;
    localparam logic [7:0] OFS_PID2_PV      = 8'h4C;
    localparam logic [7:0] OFS_PID2_MV      = 8'h50;
    localparam logic [7:0] OFS_PID2_CTRL    = 8'h54;
    localparam logic [7:0] OFS_PID_ACTION   = 8'h58;
    localparam logic [7:0] OFS_PID2_ACTION  = 8'h5C;
    localparam logic [7:0] OFS_INC_SCALE    = 8'h60;
    localparam logic [7:0] OFS_PRESCALE     = 8'h64;
    localparam logic [7:0] OFS_AOUT_SEL     = 8'h68;
    localparam logic [7:0] OFS_PULSE_IO_SEL = 8'h6C;
    localparam logic [7:0] OFS_PULSE_DIV    = 8'h70;

    localparam int NUM_AIN  = 4;
    localparam int NUM_AOUT = 5;

    localparam logic [15:0] AOUT_SRC_PROGRAM = 16'h0046; // 70
    localparam logic [15:0] SAMPLE_MAX       = 16'h7FFF; // 32767
    localparam logic [15:0] PRESCALE_MAX     = 16'h7FFF;
    localparam logic [15:0] PRESCALE_RESET   = 16'h0001;
    localparam logic [2:0]  INC_SCALE_RESET  = 3'h0;
    localparam logic [2:0]  INC_SCALE_MAX    = 3'h5;
    localparam logic [31:0] CUM_MAX          = 32'h05F5_E0FF; // 99999999

    // pid action codes
    localparam logic [15:0] ACT_DEV_REV_RUN  = 16'h0046; // 70
    localparam logic [15:0] ACT_DEV_FWD_RUN  = 16'h0047; // 71
    localparam logic [15:0] ACT_MS_REV_RUN   = 16'h0050; // 80
    localparam logic [15:0] ACT_MS_FWD_RUN   = 16'h0051; // 81
    localparam logic [15:0] ACT_DEV_REV_FREE = 16'h005A; // 90
    localparam logic [15:0] ACT_DEV_FWD_FREE = 16'h005B; // 91
    localparam logic [15:0] ACT_MS_REV_FREE  = 16'h0064; // 100
    localparam logic [15:0] ACT_MS_FWD_FREE  = 16'h0065; // 101

    // 0.01 % units
    localparam logic signed [15:0] PCT_MAX = 16'sh2710; // +100.00
    localparam logic signed [15:0] PCT_MIN = -16'sh2710;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MUL  = 3'b010,
        ST_ACC  = 3'b100
    } pior_cnt_state_type;

    typedef struct packed {
        logic        active;   // pid output may update
        logic        forward;
        logic        deviation;
        logic        enabled;
    } pior_pid_mode_type;

endpackage

// ### verification/pior_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module pior_field_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        scan_req,
    input  wire logic [63:0] ain_level,
    input  wire logic [15:0] pulses,
    output logic             end_of_scan,
    output logic      [63:0] analog_in_raw,
    output logic      [15:0] pulse_in_count
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            end_of_scan <= 1'b0;
        end else begin
            end_of_scan <= scan_req;
        end
    end
    // raw terminal level straight through, no smoothing
    assign analog_in_raw = ain_level;
    // count is only valid on the strobe; garbage elsewhere
    assign pulse_in_count = end_of_scan ? pulses : ~pulses;
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pior_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, cum;
    logic [79:0] analog_out;
    logic [63:0] analog_in_raw, ain_level;
    logic [15:0] pulse_in_count, pulses, v, sp, pv, act;
    logic        end_of_scan, scan_req, drive_running, pid_freq_apply;
    logic        pid_enable_input, second_pid_enable_input;
    logic        pid_enable_assigned, second_pid_enable_assigned;
    logic [16:0] exp_q[$];
    logic signed [16:0] e;
    int          error_cnt, total_checks, seed, k, p;
    logic [15:0] acts [8] = '{ACT_DEV_REV_RUN, ACT_DEV_FWD_RUN,
        ACT_MS_REV_RUN, ACT_MS_FWD_RUN, ACT_DEV_REV_FREE,
        ACT_DEV_FWD_FREE, ACT_MS_REV_FREE, ACT_MS_FWD_FREE};

    pior_bank i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .end_of_scan, .analog_in_raw,
        .analog_out, .pulse_in_count, .drive_running, .pid_enable_input,
        .second_pid_enable_input, .pid_enable_assigned,
        .second_pid_enable_assigned, .pid_freq_apply);
    pior_field_model i_field (.pclk, .presetn, .scan_req, .ain_level,
        .pulses, .end_of_scan, .analog_in_raw, .pulse_in_count);

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // bit 16 of a note is the expected error response
    task automatic rd(input logic [7:0] a, input logic [16:0] exp);
        exp_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic scan;
        @(posedge pclk);
        scan_req <= 1'b1;
        @(posedge pclk);
        scan_req <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            cmp({pslverr, prdata[15:0]}, exp_q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, scan_req} = '0;
        {ain_level, pulses, drive_running, second_pid_enable_input} = '0;
        {pid_enable_input, pid_enable_assigned} = 2'b11;
        second_pid_enable_assigned = 1'b0;
        seed = 55;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_INC_SCALE, 17'h00000);
        rd(OFS_PRESCALE, 17'h00001);
        rd(8'h7C, 17'h10000);
        wr(OFS_AIN_ONE, 32'h0000_1234);
        ain_level <= {$random(seed), $random(seed)};
        rd(OFS_AIN_ONE, 17'h00000);
        scan();
        for (k = 0; k < NUM_AIN; k++) begin
            rd(8'(k * 4), {1'b0, ain_level[16*k +: 16]});
        end
        v = ain_level[31:16];
        ain_level <= ~ain_level;
        rd(OFS_AIN_TWO, {1'b0, v});
        for (k = 0; k < NUM_AOUT; k++) begin
            v = 16'($random(seed)) & 16'h03FF;
            wr(OFS_AOUT_SEL, {13'h0, 3'(k), AOUT_SRC_PROGRAM});
            wr(OFS_AOUT_METER + 8'(k * 4), {16'h0, v});
            rd(OFS_AOUT_METER + 8'(k * 4), {1'b0, v});
            cmp({1'b0, analog_out[16*k +: 16]}, 17'h00000);
            scan();
            cmp({1'b0, analog_out[16*k +: 16]}, {1'b0, v});
        end
        ////////////////////////////////////////////////////////////////////
        for (k = 0; k < 4; k++) begin
            v = (k == 3) ? 16'h0064 : 16'(k * 10 + 1);
            wr(OFS_PULSE_IO_SEL, {16'h0, v});
            rd(OFS_PULSE_IO_SEL, {1'b0, v});
        end
        wr(OFS_PULSE_DIV, 32'h0);
        wr(OFS_PRESCALE, 32'h0000_2710);
        wr(OFS_PULSE_RUN, 32'h1);
        cum = 32'h0;
        for (k = 1; k <= 5; k++) begin
            wr(OFS_INC_SCALE, 32'(k));
            p = {$random(seed)} % 3 + 1;
            pulses <= 16'(p);
            v = 16'(p * 10000 / (10 ** (k - 1)));
            cum = cum + 32'(v);
            scan();
            rd(OFS_PULSE_SAMPLE, {1'b0, v});
            rd(OFS_PULSE_CUM_LO, {1'b0, cum[15:0]});
            rd(OFS_PULSE_CUM_HI, {1'b0, cum[31:16]});
        end
        wr(OFS_INC_SCALE, 32'h6);
        wr(OFS_PRESCALE, 32'h0000_8000);
        rd(OFS_INC_SCALE, 17'h00005);
        rd(OFS_PRESCALE, 17'h02710);
        wr(OFS_PRESCALE, 32'h0000_7FFF);
        wr(OFS_INC_SCALE, 32'h1);
        pulses <= 16'h0002;
        cum = cum + 32'h7FFF;
        scan();
        rd(OFS_PULSE_SAMPLE, {1'b0, SAMPLE_MAX});
        wr(OFS_PULSE_RUN, 32'h0);
        scan();
        rd(OFS_PULSE_SAMPLE, {1'b0, SAMPLE_MAX});
        rd(OFS_PULSE_CUM_LO, {1'b0, cum[15:0]});
        wr(OFS_PULSE_CLEAR, 32'h1);
        scan();
        rd(OFS_PULSE_CUM_LO, 17'h00000);
        rd(OFS_PULSE_SAMPLE, 17'h00000);
        rd(OFS_PULSE_CLEAR, 17'h00000);
        ////////////////////////////////////////////////////////////////////
        wr(OFS_PID_ACTION, {16'h0, ACT_DEV_REV_RUN});
        wr(OFS_PID_SP, 32'h0000_0100);
        wr(OFS_PID_CTRL, 32'h1);
        scan();
        rd(OFS_PID_MV, 17'h00000);
        drive_running <= 1'b1;
        for (k = 0; k < 8; k++) begin
            act = acts[k];
            p = (k % 2) * 16;
            sp = 16'({$random(seed)} % 12000);
            pv = 16'({$random(seed)} % 10001);
            wr(OFS_PID_ACTION + 8'(k % 2 * 4), {16'h0, act});
            wr(OFS_PID_SP + 8'(p), {16'h0, sp});
            wr(OFS_PID_PV + 8'(p), {16'h0, pv});
            wr(OFS_PID_CTRL + 8'(p), 32'h1);
            scan();
            cmp({16'h0, pid_freq_apply}, {16'h0, (act < ACT_DEV_REV_FREE) ||
                (k > 0 && acts[k > 0 ? k - 1 : 0] < ACT_DEV_REV_FREE)});
            // above full scale must act as full scale
            if (sp > 16'd10000) sp = 16'd10000;
            e = $signed({1'b0, sp});
            if (!(act inside {ACT_DEV_REV_RUN, ACT_DEV_FWD_RUN,
                ACT_DEV_REV_FREE, ACT_DEV_FWD_FREE})) e = e - 17'(pv);
            if (!act[0]) e = -e;
            rd(OFS_PID_MV + 8'(p), {1'b0, e[15:0]});
        end
        give_verdict();
    end
endmodule
`default_nettype wire
